// *** verilog/rx_frame_params.svh ***
`ifndef RX_FRAME_PARAMS_SVH
`define RX_FRAME_PARAMS_SVH

// ============================================================
// Register indices; the byte address is four times the index.
`define IDX_IRQ_ENABLE   10'h0A1
`define IDX_IRQ_FLAGS    10'h0A2
`define IDX_MIN_LEN      10'h0A3
`define IDX_MAX_LEN_LOW  10'h0A4
`define IDX_MAX_LEN_HIGH 10'h0A5
`define IDX_RESTART      10'h0A6
`define IDX_HIGH_WATER   10'h0A7
`define IDX_COUNT_LOW    10'h0A8
`define IDX_COUNT_MID    10'h0A9
`define IDX_COUNT_UPPER  10'h0AA

// ============================================================
// Reset values.
`define RST_IRQ_ENABLE   8'h00
`define RST_MIN_LEN      8'h04
`define RST_MAX_LEN      16'h0600
`define RST_RESTART      8'h8C
`define RST_HIGH_WATER   8'h40

// ============================================================
// Status and enable bit positions.
`define BIT_OVERRUN      1
`define BIT_CHECKSUM     2
`define BIT_ABORTED      3
`define BIT_OVERSIZE     4
`define BIT_UNDERSIZE    5
`define FLAG_MASK        8'h3E

// ============================================================
// Widths and bus answers.
`define LEN_W            16
`define COUNT_W          24
`define FIFO_LEVEL_W     9
`define RESTART_CODE_W   4
`define RESTART_SHIFT    4'h4
`define AXI_ADDR_W       12
`define AXI_OKAY         2'b00
`define AXI_SLVERR       2'b10

`endif

// *** verilog/rx_frame_pkg.sv ***
`default_nettype none
package rx_frame_pkg;

  // ============================================================
  // Outcome of one received frame, valid for the cycle of done.
  typedef struct packed {
    logic        done;
    logic        error;
    logic        oversize;
    logic        undersize;
    logic        checksum;
    logic        aborted;
    logic        overrun;
    logic [15:0] length;
  } frame_result_t;

  // ============================================================
  // Write gate of the receive FIFO.
  typedef enum logic [1:0] {
    GATE_OPEN      = 2'b01,
    GATE_SUSPENDED = 2'b10
  } gate_state_t;

endpackage
`default_nettype wire

// *** verilog/frame_length_checker.sv ***
`include "rx_frame_params.svh"
`default_nettype none
module frame_length_checker (
  // Clock and reset.
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  // Frame stream.
  input  wire logic                 byte_strobe,
  input  wire logic                 frame_end,
  input  wire logic                 fcs_bad,
  input  wire logic                 abort_seen,
  input  wire logic                 byte_dropped,
  // Limits.
  input  wire logic [7:0]           min_len,
  input  wire logic [`LEN_W-1:0]    max_len,
  // Result.
  output rx_frame_pkg::frame_result_t result
);
  import rx_frame_pkg::*;

  logic [`LEN_W-1:0] count;
  logic              dropped;
  logic [`LEN_W-1:0] len_now;
  logic              over;
  logic              under;
  logic              dropped_now;

  // ============================================================
  // Length seen at the end, counting a byte of the end cycle too.
  assign len_now     = (byte_strobe && count != {`LEN_W{1'b1}}) ? count + 1'b1 : count;
  assign over        = len_now > max_len;
  assign under       = len_now < {8'h00, min_len};
  assign dropped_now = dropped | byte_dropped;

  always_ff @(posedge clk) begin
    if (!reset_n || frame_end) begin
      count   <= '0;
      dropped <= 1'b0;
    end else begin
      count   <= len_now;
      dropped <= dropped_now;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      result <= '0;
    end else begin
      result.done      <= frame_end;
      result.oversize  <= frame_end & over;
      result.undersize <= frame_end & under;
      result.checksum  <= frame_end & fcs_bad;
      result.aborted   <= frame_end & abort_seen;
      result.overrun   <= frame_end & dropped_now;
      result.error     <= frame_end & (over | under | fcs_bad | abort_seen | dropped_now);
      result.length    <= len_now;
    end
  end

endmodule
`default_nettype wire

// *** verilog/fifo_restart_gate.sv ***
`include "rx_frame_params.svh"
`default_nettype none
module fifo_restart_gate (
  // Clock and reset.
  input  wire logic                      clk,
  input  wire logic                      reset_n,
  // FIFO state.
  input  wire logic                      overrun,
  input  wire logic [`FIFO_LEVEL_W-1:0]  fifo_used,
  input  wire logic [`RESTART_CODE_W-1:0] restart_code,
  // Gate.
  output logic                           write_open
);
  import rx_frame_pkg::*;

  gate_state_t              state;
  gate_state_t              next_state;
  logic [`FIFO_LEVEL_W-1:0] restart_bytes;
  logic                     below_level;

  // ============================================================
  // Code times sixteen bytes.
  assign restart_bytes = {1'b0, restart_code, 4'h0};
  assign below_level   = fifo_used < restart_bytes;

  always_comb begin
    next_state = state;
    unique case (state)
      GATE_OPEN: begin
        if (overrun) begin
          next_state = GATE_SUSPENDED;
        end
      end
      GATE_SUSPENDED: begin
        if (!overrun && below_level) begin
          next_state = GATE_OPEN;
        end
      end
      default: begin
        next_state = GATE_SUSPENDED;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state      <= GATE_OPEN;
      write_open <= 1'b1;
    end else begin
      state      <= next_state;
      write_open <= (next_state == GATE_OPEN);
    end
  end

endmodule
`default_nettype wire

// *** verilog/rx_frame_control.sv ***
// What this block does
// - Set the overrun flag on FIFO overrun; interrupt only while its enable is set.
// - Set the checksum error flag on a frame check failure, maskable by its enable.
// - Set the aborted packet flag on an aborted packet, maskable by its enable.
// - Set the oversize flag for packets longer than the maximum, maskable by enable.
// - Set the undersize flag for packets shorter than the minimum, maskable by enable.
// - An enable at one lets its condition interrupt; at zero it cannot.
// - Mark with an error every packet shorter than the eight-bit minimum.
// - Packet length counts payload bytes only, no stuffing and no check sequence.
// - Oversize packets show error with end of packet, count bytes, set the flag.
// - After overrun, suspend FIFO writes until the used count falls below the level.
// - The four-bit restart code selects code times sixteen bytes; reset gives 192.
// - Packet available is high when fill exceeds the mark or an end is held.
// - Byte count bits 23 to 0 read as three read-only bytes.
// - The byte counter counts FIFO bytes, leaving out undersize, checksum, overrun and aborted frames; oversize frames count.
// - A counter write snapshots the count and restarts it, keeping a coinciding event.
//
// Added by the designer: register access over AXI4-Lite.
`include "rx_frame_params.svh"
`default_nettype none
module rx_frame_control (
  // Clock and reset.
  input  wire logic                      CLK,
  input  wire logic                      RESET_N,
  // Receive frame stream.
  input  wire logic                      RX_BYTE_STROBE,
  input  wire logic                      RX_FRAME_END,
  input  wire logic                      RX_FCS_BAD,
  input  wire logic                      RX_ABORT,
  // Receive FIFO state.
  input  wire logic                      FIFO_OVERRUN,
  input  wire logic [`FIFO_LEVEL_W-1:0]  FIFO_USED,
  input  wire logic                      FIFO_EOP_HELD,
  // Link-layer side.
  output logic                           FIFO_WRITE_ENABLE,
  output logic                           PACKET_AVAILABLE_OUT,
  output logic                           RECEIVE_ERROR_OUT,
  output logic                           RECEIVE_END_OF_PACKET_OUT,
  output logic                           IRQ,
  // AXI4-Lite write channels.
  input  wire logic [`AXI_ADDR_W-1:0]    AWADDR,
  input  wire logic                      AWVALID,
  output logic                           AWREADY,
  input  wire logic [31:0]               WDATA,
  input  wire logic [3:0]                WSTRB,
  input  wire logic                      WVALID,
  output logic                           WREADY,
  output logic [1:0]                     BRESP,
  output logic                           BVALID,
  input  wire logic                      BREADY,
  // AXI4-Lite read channels.
  input  wire logic [`AXI_ADDR_W-1:0]    ARADDR,
  input  wire logic                      ARVALID,
  output logic                           ARREADY,
  output logic [31:0]                    RDATA,
  output logic [1:0]                     RRESP,
  output logic                           RVALID,
  input  wire logic                      RREADY
);
  import rx_frame_pkg::*;

  // ============================================================
  // Registers.
  logic [7:0]          irq_enable;
  logic [7:0]          rx_frame_irq_flags;
  logic [7:0]          rx_min_packet_len;
  logic [`LEN_W-1:0]   max_length_limit;
  logic [7:0]          rx_restart_fill_level;
  logic [7:0]          rx_avail_high_water;
  logic [`COUNT_W-1:0] count_live;
  logic [`COUNT_W-1:0] received_byte_count;
  frame_result_t       result;

  // ============================================================
  // Bus decode.
  logic [9:0]  wr_index;
  logic [9:0]  rd_index;
  logic        write_fire;
  logic        read_fire;
  logic        wr_lane0;
  logic        wr_counter;
  logic        wr_known;
  logic        rd_known;
  logic [7:0]  rd_byte;
  logic [7:0]  flags_read;

  assign wr_index   = AWADDR[`AXI_ADDR_W-1:2];
  assign rd_index   = ARADDR[`AXI_ADDR_W-1:2];
  assign write_fire = AWVALID && WVALID && !AWREADY && !BVALID;
  assign read_fire  = ARVALID && !ARREADY && !RVALID;
  assign wr_lane0   = write_fire && WSTRB[0];
  assign wr_counter = wr_lane0 && (wr_index == `IDX_COUNT_LOW
                                || wr_index == `IDX_COUNT_MID
                                || wr_index == `IDX_COUNT_UPPER);
  assign wr_known   = wr_index >= `IDX_IRQ_ENABLE && wr_index <= `IDX_COUNT_UPPER;
  assign rd_known   = rd_index >= `IDX_IRQ_ENABLE && rd_index <= `IDX_COUNT_UPPER;

  assign rd_byte =
    (rd_index == `IDX_IRQ_ENABLE)   ? irq_enable :
    (rd_index == `IDX_IRQ_FLAGS)    ? rx_frame_irq_flags :
    (rd_index == `IDX_MIN_LEN)      ? rx_min_packet_len :
    (rd_index == `IDX_MAX_LEN_LOW)  ? max_length_limit[7:0] :
    (rd_index == `IDX_MAX_LEN_HIGH) ? max_length_limit[15:8] :
    (rd_index == `IDX_RESTART)      ? rx_restart_fill_level :
    (rd_index == `IDX_HIGH_WATER)   ? rx_avail_high_water :
    (rd_index == `IDX_COUNT_LOW)    ? received_byte_count[7:0] :
    (rd_index == `IDX_COUNT_MID)    ? received_byte_count[15:8] :
    (rd_index == `IDX_COUNT_UPPER)  ? received_byte_count[23:16] :
    8'h00;

  // Flags returned by this read are the ones it clears.
  assign flags_read = (read_fire && rd_index == `IDX_IRQ_FLAGS) ? rx_frame_irq_flags : 8'h00;

  // ============================================================
  // Write channel.
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      AWREADY <= 1'b0;
      WREADY  <= 1'b0;
      BVALID  <= 1'b0;
      BRESP   <= `AXI_OKAY;
    end else begin
      AWREADY <= write_fire;
      WREADY  <= write_fire;
      if (write_fire) begin
        BVALID <= 1'b1;
        BRESP  <= wr_known ? `AXI_OKAY : `AXI_SLVERR;
      end else if (BREADY) begin
        BVALID <= 1'b0;
      end
    end
  end

  // ============================================================
  // Read channel.
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      ARREADY <= 1'b0;
      RVALID  <= 1'b0;
      RDATA   <= 32'h0000_0000;
      RRESP   <= `AXI_OKAY;
    end else begin
      ARREADY <= read_fire;
      if (read_fire) begin
        RVALID <= 1'b1;
        RDATA  <= {24'h00_0000, rd_byte};
        RRESP  <= rd_known ? `AXI_OKAY : `AXI_SLVERR;
      end else if (RREADY) begin
        RVALID <= 1'b0;
      end
    end
  end

  // ============================================================
  // Control registers.
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      irq_enable            <= `RST_IRQ_ENABLE;
      rx_min_packet_len     <= `RST_MIN_LEN;
      max_length_limit      <= `RST_MAX_LEN;
      rx_restart_fill_level <= `RST_RESTART;
      rx_avail_high_water   <= `RST_HIGH_WATER;
    end else if (wr_lane0) begin
      if (wr_index == `IDX_IRQ_ENABLE) begin
        irq_enable <= WDATA[7:0] & `FLAG_MASK;
      end
      if (wr_index == `IDX_MIN_LEN) begin
        rx_min_packet_len <= WDATA[7:0];
      end
      if (wr_index == `IDX_MAX_LEN_LOW) begin
        max_length_limit[7:0] <= WDATA[7:0];
      end
      if (wr_index == `IDX_MAX_LEN_HIGH) begin
        max_length_limit[15:8] <= WDATA[7:0];
      end
      if (wr_index == `IDX_RESTART) begin
        rx_restart_fill_level <= WDATA[7:0];
      end
      if (wr_index == `IDX_HIGH_WATER) begin
        rx_avail_high_water <= WDATA[7:0];
      end
    end
  end

  // ============================================================
  // Frame checks and FIFO write gate.
  logic byte_dropped;

  assign byte_dropped = RX_BYTE_STROBE && (!FIFO_WRITE_ENABLE || FIFO_OVERRUN);

  frame_length_checker u_checker (
    .clk          (CLK),
    .reset_n      (RESET_N),
    .byte_strobe  (RX_BYTE_STROBE),
    .frame_end    (RX_FRAME_END),
    .fcs_bad      (RX_FCS_BAD),
    .abort_seen   (RX_ABORT),
    .byte_dropped (byte_dropped),
    .min_len      (rx_min_packet_len),
    .max_len      (max_length_limit),
    .result       (result)
  );

  fifo_restart_gate u_gate (
    .clk          (CLK),
    .reset_n      (RESET_N),
    .overrun      (FIFO_OVERRUN),
    .fifo_used    (FIFO_USED),
    .restart_code (rx_restart_fill_level[`RESTART_CODE_W-1:0]),
    .write_open   (FIFO_WRITE_ENABLE)
  );

  // ============================================================
  // Status flags; a new event wins over the clearing read.
  logic [7:0] flag_set;

  assign flag_set[0]              = 1'b0;
  assign flag_set[`BIT_OVERRUN]   = FIFO_OVERRUN;
  assign flag_set[`BIT_CHECKSUM]  = result.checksum;
  assign flag_set[`BIT_ABORTED]   = result.aborted;
  assign flag_set[`BIT_OVERSIZE]  = result.oversize;
  assign flag_set[`BIT_UNDERSIZE] = result.undersize;
  assign flag_set[7:6]            = 2'b00;

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      rx_frame_irq_flags <= 8'h00;
      IRQ                <= 1'b0;
    end else begin
      rx_frame_irq_flags <= (rx_frame_irq_flags & ~flags_read) | flag_set;
      IRQ                <= |(rx_frame_irq_flags & irq_enable);
    end
  end

  // ============================================================
  // Link-layer indications.
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      PACKET_AVAILABLE_OUT      <= 1'b0;
      RECEIVE_ERROR_OUT         <= 1'b0;
      RECEIVE_END_OF_PACKET_OUT <= 1'b0;
    end else begin
      PACKET_AVAILABLE_OUT      <= (FIFO_USED > {1'b0, rx_avail_high_water})
                                   || FIFO_EOP_HELD;
      RECEIVE_ERROR_OUT         <= result.done && result.error;
      RECEIVE_END_OF_PACKET_OUT <= result.done;
    end
  end

  // ============================================================
  // Received byte counter with snapshot.
  logic                good_frame;
  logic [`COUNT_W-1:0] add_bytes;
  logic [`COUNT_W-1:0] sum_bytes;

  assign good_frame = result.done && !(result.undersize || result.checksum
                      || result.aborted || result.overrun);
  assign add_bytes  = good_frame ? {8'h00, result.length} : '0;
  assign sum_bytes  = (count_live > ~add_bytes) ? {`COUNT_W{1'b1}} : count_live + add_bytes;

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      count_live          <= '0;
      received_byte_count <= '0;
    end else if (wr_counter) begin
      received_byte_count <= count_live;
      count_live          <= add_bytes;
    end else begin
      count_live          <= sum_bytes;
    end
  end

endmodule
`default_nettype wire

// *** verif/rx_frame_control_chk.sv ***
`include "rx_frame_params.svh"
`default_nettype none
module rx_frame_control_chk (
  // Clock and reset.
  input wire logic                     CLK,
  input wire logic                     RESET_N,
  // Frame stream and FIFO state.
  input wire logic                     RX_FRAME_END,
  input wire logic                     FIFO_OVERRUN,
  input wire logic [`FIFO_LEVEL_W-1:0] FIFO_USED,
  input wire logic                     FIFO_EOP_HELD,
  // Outputs watched.
  input wire logic                     FIFO_WRITE_ENABLE,
  input wire logic                     PACKET_AVAILABLE_OUT,
  input wire logic                     RECEIVE_ERROR_OUT,
  input wire logic                     RECEIVE_END_OF_PACKET_OUT,
  input wire logic                     IRQ,
  // Bus answers.
  input wire logic                     AWREADY,
  input wire logic                     WREADY,
  input wire logic [1:0]               BRESP,
  input wire logic                     BVALID,
  input wire logic                     BREADY,
  input wire logic [31:0]              RDATA,
  input wire logic                     RVALID,
  input wire logic                     RREADY
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  // ============================================================
  // Frame results.
  eop_delay_a: assert property (RX_FRAME_END |-> ##2 RECEIVE_END_OF_PACKET_OUT)
    else $error("end of packet not two cycles after frame end");
  eop_cause_a: assert property (RECEIVE_END_OF_PACKET_OUT |-> $past(RX_FRAME_END, 2))
    else $error("end of packet without a frame end");
  err_with_eop_a: assert property (RECEIVE_ERROR_OUT |-> RECEIVE_END_OF_PACKET_OUT)
    else $error("receive error apart from end of packet");
  // ============================================================
  // FIFO gate and packet available.
  ovr_close_a: assert property (FIFO_OVERRUN |=> !FIFO_WRITE_ENABLE)
    else $error("writes not suspended after overrun");
  reopen_cause_a: assert property ($rose(FIFO_WRITE_ENABLE) |->
    $past(FIFO_USED) < 9'd240 && !$past(FIFO_OVERRUN))
    else $error("writes resumed above any restart level");
  avail_level_a: assert property (($past(FIFO_EOP_HELD) || $past(FIFO_USED[8]))
    && $past(RESET_N) |-> PACKET_AVAILABLE_OUT)
    else $error("packet available low with end held or full FIFO");
  // ============================================================
  // Register bus.
  bresp_hold_a: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response dropped before accepted");
  rdata_hold_a: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read data dropped before accepted");
  rdata_byte_a: assert property (RVALID |-> RDATA[31:8] == 24'h000000)
    else $error("upper read data bits not zero");
  cover property (RECEIVE_ERROR_OUT);
  cover property ($rose(FIFO_WRITE_ENABLE));
  cover property ($rose(IRQ));
endmodule
bind rx_frame_control rx_frame_control_chk chk_u (.CLK, .RESET_N, .RX_FRAME_END,
  .FIFO_OVERRUN, .FIFO_USED, .FIFO_EOP_HELD, .FIFO_WRITE_ENABLE, .PACKET_AVAILABLE_OUT,
  .RECEIVE_ERROR_OUT, .RECEIVE_END_OF_PACKET_OUT, .IRQ, .AWREADY, .WREADY, .BRESP,
  .BVALID, .BREADY, .RDATA, .RVALID, .RREADY);
`default_nettype wire

// *** verif/fifo_reader_model.sv ***
`default_nettype none
module fifo_reader_model (
  // Clock and reset.
  input wire logic        clk,
  input wire logic        reset_n,
  // Control from the bench and the block.
  input wire logic        write_enable,
  input wire logic [9:0]  goal,
  input wire logic        eop_in,
  // FIFO state.
  output logic [8:0]      used,
  output logic            eop_held,
  output logic            overrun
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      used <= 9'h000;
    end else if (used > goal) begin
      used <= used - 9'h001;
    end else if (used < goal && write_enable && used != 9'h100) begin
      used <= used + 9'h001;
    end
  end
  assign overrun  = write_enable && used == 9'h100 && goal > 10'h100;
  assign eop_held = eop_in;
endmodule
`default_nettype wire

// *** verif/rx_frame_control_tb_top.sv ***
`include "rx_frame_params.svh"
`default_nettype none
module rx_frame_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        CLK, RESET_N, RX_BYTE_STROBE, RX_FRAME_END, RX_FCS_BAD, RX_ABORT;
  logic        FIFO_OVERRUN, FIFO_EOP_HELD, FIFO_WRITE_ENABLE, PACKET_AVAILABLE_OUT;
  logic        RECEIVE_ERROR_OUT, RECEIVE_END_OF_PACKET_OUT, IRQ, eop_in;
  logic [8:0]  FIFO_USED;
  logic [9:0]  goal;
  logic [11:0] AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA, rdv;
  logic [3:0]  WSTRB;
  logic [1:0]  BRESP, RRESP, rsp;
  logic        AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
  logic        ARVALID, ARREADY, RVALID, RREADY;
  int          fails, tests_run, cycles;
  rx_frame_control dut_u (.CLK, .RESET_N, .RX_BYTE_STROBE, .RX_FRAME_END, .RX_FCS_BAD,
    .RX_ABORT, .FIFO_OVERRUN, .FIFO_USED, .FIFO_EOP_HELD, .FIFO_WRITE_ENABLE,
    .PACKET_AVAILABLE_OUT, .RECEIVE_ERROR_OUT, .RECEIVE_END_OF_PACKET_OUT, .IRQ, .AWADDR,
    .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY,
    .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY);
  fifo_reader_model peer_u (.clk(CLK), .reset_n(RESET_N), .write_enable(FIFO_WRITE_ENABLE),
    .goal(goal), .eop_in(eop_in), .used(FIFO_USED), .eop_held(FIFO_EOP_HELD),
    .overrun(FIFO_OVERRUN));
  // ============================================================
  // Helpers.
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge CLK);
    AWADDR  <= a;
    WDATA   <= {24'h000000, d};
    WSTRB   <= 4'hF;
    AWVALID <= 1'b1;
    WVALID  <= 1'b1;
    forever begin
      @(posedge CLK);
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
      if (BVALID && BREADY) break;
      if (BVALID) BREADY <= 1'b1;
    end
    BREADY <= 1'b0;
    rsp = BRESP;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge CLK);
    ARADDR  <= a;
    ARVALID <= 1'b1;
    forever begin
      @(posedge CLK);
      if (ARREADY) ARVALID <= 1'b0;
      if (RVALID && RREADY) break;
      if (RVALID) RREADY <= 1'b1;
    end
    RREADY <= 1'b0;
    rdv = RDATA;
    rsp = RRESP;
  endtask
  task automatic send(input int n, input logic f, input logic ab, output logic er, output logic eo);
    er = 1'b0;
    eo = 1'b0;
    repeat (n) begin
      @(posedge CLK);
      RX_BYTE_STROBE <= 1'b1;
    end
    @(posedge CLK);
    RX_BYTE_STROBE <= 1'b0;
    RX_FRAME_END   <= 1'b1;
    RX_FCS_BAD     <= f;
    RX_ABORT       <= ab;
    @(posedge CLK);
    RX_FRAME_END <= 1'b0;
    RX_FCS_BAD   <= 1'b0;
    RX_ABORT     <= 1'b0;
    repeat (4) begin
      @(posedge CLK);
      if (RECEIVE_END_OF_PACKET_OUT === 1'b1) begin
        eo = 1'b1;
        er = RECEIVE_ERROR_OUT;
      end
    end
  endtask
  task automatic await(input logic [8:0] n);
    while (FIFO_USED !== n) @(posedge CLK);
    repeat (3) @(posedge CLK);
  endtask
  // ============================================================
  // Scenarios.
  task automatic reg_reset_scn;
    logic [11:0] a [9] = '{12'h284, 12'h28C, 12'h290, 12'h294, 12'h298, 12'h29C, 12'h2A0,
                           12'h2A4, 12'h2A8};
    logic [7:0]  v [9] = '{8'h00, 8'h04, 8'h00, 8'h06, 8'h8C, 8'h40, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 9; i++) begin
      rd(a[i]);
      chk("reset value", rdv, {24'h000000, v[i]});
    end
    rd(12'h300);
    chk("unmapped response", {30'h0, rsp}, {30'h0, `AXI_SLVERR});
    wr(12'h300, 8'h00);
    chk("unmapped write response", {30'h0, rsp}, {30'h0, `AXI_SLVERR});
    wr(12'h288, 8'hFF);
    chk("flags write response", {30'h0, rsp}, {30'h0, `AXI_OKAY});
    rd(12'h288);
    chk("flags not writable", rdv, 32'h0);
  endtask
  task automatic length_scn;
    int          n [6] = '{3, 4, 16, 17, 8, 8};
    logic [7:0]  fl [6] = '{8'h20, 8'h00, 8'h00, 8'h10, 8'h04, 8'h08};
    logic        er, eo;
    wr(12'h290, 8'h10);
    wr(12'h294, 8'h00);
    wr(12'h284, 8'h3E);
    for (int i = 0; i < 6; i++) begin
      send(n[i], i == 4, i == 5, er, eo);
      chk("end of packet", eo, 1);
      chk("receive error", er, fl[i] != 8'h00);
      chk("irq", IRQ, fl[i] != 8'h00);
      rd(12'h288);
      chk("flags", rdv, fl[i]);
      rd(12'h288);
      chk("flags cleared", rdv, 0);
    end
  endtask
  task automatic mask_scn;
    logic er, eo;
    wr(12'h284, 8'h10);
    send(3, 0, 0, er, eo);
    chk("masked irq", IRQ, 0);
    send(17, 0, 0, er, eo);
    chk("enabled irq", IRQ, 1);
    rd(12'h288);
    chk("both flags", rdv, 8'h30);
    repeat (2) @(posedge CLK);
    chk("irq after clear", IRQ, 0);
  endtask
  task automatic count_scn;
    logic er, eo;
    wr(12'h2A0, 8'h00);
    wr(12'h290, 8'h40);
    wr(12'h294, 8'h01);
    send(200, 0, 0, er, eo);
    send(100, 0, 0, er, eo);
    send(330, 0, 0, er, eo);
    send(10, 1, 0, er, eo);
    send(12, 0, 1, er, eo);
    wr(12'h2A4, 8'h00);
    repeat (3) @(posedge CLK);
    rd(12'h2A0);
    chk("count low", rdv, 8'h76);
    rd(12'h2A4);
    chk("count mid", rdv, 8'h02);
    rd(12'h2A8);
    chk("count upper", rdv, 8'h00);
    wr(12'h2A8, 8'h00);
    repeat (3) @(posedge CLK);
    rd(12'h2A0);
    chk("count restarted", rdv, 8'h00);
    rd(12'h288);
    chk("error flags", rdv, 8'h1C);
  endtask
  task automatic fifo_scn;
    wr(12'h298, 8'h02);
    wr(12'h284, 8'h02);
    goal <= 10'd300;
    while (FIFO_WRITE_ENABLE !== 1'b0) @(posedge CLK);
    repeat (2) @(posedge CLK);
    chk("overrun irq", IRQ, 1);
    rd(12'h288);
    chk("overrun flag", rdv, 8'h02);
    goal <= 10'd32;
    await(9'd32);
    chk("still suspended", FIFO_WRITE_ENABLE, 0);
    goal <= 10'd31;
    await(9'd31);
    chk("resumed", FIFO_WRITE_ENABLE, 1);
    goal <= 10'd64;
    await(9'd64);
    chk("avail at mark", PACKET_AVAILABLE_OUT, 0);
    goal <= 10'd65;
    await(9'd65);
    chk("avail above mark", PACKET_AVAILABLE_OUT, 1);
    goal   <= 10'd0;
    eop_in <= 1'b1;
    await(9'd0);
    chk("avail end held", PACKET_AVAILABLE_OUT, 1);
    eop_in <= 1'b0;
    repeat (3) @(posedge CLK);
    chk("avail empty", PACKET_AVAILABLE_OUT, 0);
  endtask
  // ============================================================
  // Clock, timeout and main sequence.
  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 40000) begin
      fails++;
      tally_and_finish;
    end
  end
  initial begin
    {RESET_N, RX_BYTE_STROBE, RX_FRAME_END, RX_FCS_BAD, RX_ABORT, eop_in} = '0;
    {AWVALID, WVALID, BREADY, ARVALID, RREADY} = '0;
    {AWADDR, ARADDR, WDATA, WSTRB, goal} = '0;
    repeat (8) @(posedge CLK);
    RESET_N <= 1'b1;
    reg_reset_scn;
    length_scn;
    mask_scn;
    count_scn;
    fifo_scn;
    tally_and_finish;
  end
endmodule
`default_nettype wire
